//--- logic/gtc_pkg.sv
// Purpose: Shared constants and types for the gated 16-bit timer/counter.
// Assumes: AXI4-Lite register access, 32-bit data, one word per register.
// Notes:   Control byte sits in the low bits of its word; upper bits read zero.
package gtc_pkg;

  // Register byte offsets
  localparam logic [7:0] OFF_COUNT_LOW  = 8'h00;
  localparam logic [7:0] OFF_COUNT_HIGH = 8'h04;
  localparam logic [7:0] OFF_STATUS     = 8'h08;
  localparam logic [7:0] OFF_MASK       = 8'h0c;
  localparam logic [7:0] OFF_CONTROL    = 8'h10;

  // Control field positions
  localparam int CTL_RUN_BIT   = 0;
  localparam int CTL_SRC_BIT   = 1;
  localparam int CTL_NOSYN_BIT = 2;
  localparam int CTL_OSC_BIT   = 3;
  localparam int CTL_PS_LSB    = 4;
  localparam int CTL_GATE_BIT  = 6;
  localparam int CTL_UNUSED    = 7;

  // Status / mask layout: one overflow bit
  localparam int STAT_OVF_BIT = 0;

  // Reset values
  localparam logic [7:0]  CONTROL_RESET = 8'h00;
  localparam logic [15:0] COUNT_RESET   = 16'h0000;
  localparam logic        STATUS_RESET  = 1'b0;
  localparam logic        MASK_RESET    = 1'b0;

  // Timing: system clock 50 MHz, instruction cycle is four clocks (Fosc/4)
  localparam int         CLOCK_HZ       = 50_000_000;
  localparam int         OSC_PER_INSTR  = 4;
  localparam logic [1:0] PHASE_LAST     = 2'(OSC_PER_INSTR - 1);

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // Control register contents
  typedef struct packed {
    logic       gateEn;     // Count only while gate pin is low
    logic [1:0] prescale;   // 1:1, 1:2, 1:4, 1:8
    logic       oscEn;      // Low-power oscillator as count source
    logic       noSync;     // External input left unsynchronised
    logic       clkSrc;     // 1 external pin, 0 instruction clock
    logic       runEn;      // Counter may increment
  } gtc_ctl_t;

  // Pin inputs after synchronisers
  typedef struct packed {
    logic gateN;
    logic extCount;
    logic lpOsc;
    logic sleep;
    logic intOscActive;
  } gtc_pins_t;

endpackage

//--- logic/gtc_pin_sync.sv
// Purpose: Two-flop synchroniser for a group of pin inputs.
// Assumes: Inputs are asynchronous levels; reset is synchronous, active low.
// Notes:   Only the second stage may be read by downstream logic.
`timescale 1ns/10ps
`default_nettype none
module gtc_pin_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clock,  // System clock
  input  wire logic             rst_n,  // Synchronous reset, active low
  input  wire logic [WIDTH-1:0] pinIn,  // Raw pin levels
  output logic      [WIDTH-1:0] syncOut // Synchronised levels
);

  logic [WIDTH-1:0] stage1_q;

  // First stage feeds only the second
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      stage1_q <= '0;
      syncOut  <= '0;
    end else begin
      stage1_q <= pinIn;
      syncOut  <= stage1_q;
    end
  end

endmodule
`default_nettype wire

//--- logic/gtc_timer.sv
// Purpose: Gated 16-bit timer/counter with prescaler, AXI4-Lite registers.
// Assumes: One 50 MHz clock stands for Fosc; pins pass two flops first.
// Notes:   "Unsynchronised" counting takes edges at once; synchronised
//          counting waits for the next instruction-cycle boundary.
// Notes on behaviour
// - With gate enabled and timer on, count only while gate pin low.
// - Prescale field 00..11 divides input by 1, 2, 4 or 8.
// - Oscillator-enable selects low-power oscillator only when internal oscillator active.
// - External clock: no-sync set leaves input unsynchronised, clear synchronises it.
// - Internal source ignores no-sync field and counts instruction clock.
// - Clock-source 1 counts external rising edges, 0 counts Fosc/4.
// - Control bit 7 is unimplemented and reads zero.
// - Unsynchronised external edges count independently of instruction phases.
// - Asynchronous counter keeps counting while processor sleeps.
// - Asynchronous overflow can raise a wake request out of sleep.
// - Byte reads of the count return a stable value.
// - Count write racing an increment may be unpredictable; write wins here.
// - Count rolls FFFFh to 0000h and sets the overflow flag.
// - Any write to either count byte clears the prescaler.
// - Timer mode at 1:1 prescale increments once per instruction cycle.
`timescale 1ns/10ps
`default_nettype none
module gtc_timer (
  input  wire logic        clock,         // System clock, 50 MHz
  input  wire logic        rst_n,         // Synchronous reset, active low
  // AXI4-Lite slave
  input  wire logic [7:0]  s_awaddr,      // Write address
  input  wire logic        s_awvalid,     // Write address valid
  output logic             s_awready,     // Write address ready
  input  wire logic [31:0] s_wdata,       // Write data
  input  wire logic [3:0]  s_wstrb,       // Write byte strobes
  input  wire logic        s_wvalid,      // Write data valid
  output logic             s_wready,      // Write data ready
  output logic [1:0]       s_bresp,       // Write response
  output logic             s_bvalid,      // Write response valid
  input  wire logic        s_bready,      // Write response ready
  input  wire logic [7:0]  s_araddr,      // Read address
  input  wire logic        s_arvalid,     // Read address valid
  output logic             s_arready,     // Read address ready
  output logic [31:0]      s_rdata,       // Read data
  output logic [1:0]       s_rresp,       // Read response
  output logic             s_rvalid,      // Read data valid
  input  wire logic        s_rready,      // Read data ready
  // Pins and system levels
  input  wire logic        gate_in_n,     // Gate pin, count while low
  input  wire logic        ext_count_in,  // External count input
  input  wire logic        lpOscIn,       // Low-power oscillator output level
  input  wire logic        sleepIn,       // Processor asleep
  input  wire logic        intOscActive,  // Internal osc without clock out
  output logic             lpOscEnable,   // Low-power oscillator on
  output logic             irq,           // Level interrupt
  output logic             wakeReq        // Wake request from sleep
);

  typedef struct packed {
    gtc_pkg::gtc_ctl_t ctl;
    logic [15:0]       count;
    logic [2:0]        pre;       // Prescale counter
    logic [1:0]        phase;     // Position in instruction cycle
    logic              srcPrev;   // Last external source level
    logic              armed;     // Falling edge seen
    logic              pending;   // Synchronised edge waiting for boundary
    logic              ovfFlag;
    logic              ovfMask;
    logic              awFull;
    logic [7:0]        awAddr;
    logic              wFull;
    logic [31:0]       wData;
    logic [3:0]        wStrb;
    logic              awRdy;
    logic              wRdy;
    logic              bValid;
    logic [1:0]        bResp;
    logic              arRdy;
    logic              rValid;
    logic [31:0]       rData;
    logic [1:0]        rResp;
    logic              irqOut;
    logic              wakeOut;
    logic              oscOut;
  } gtc_state_t;

  gtc_state_t        st_q;
  gtc_state_t        st_d;
  gtc_pkg::gtc_pins_t pins;

  // Every pin crosses two flops before use
  gtc_pin_sync #(
    .WIDTH ($bits(gtc_pkg::gtc_pins_t))
  ) gtc_pin_sync_i (
    .clock   (clock),
    .rst_n   (rst_n),
    .pinIn   ({gate_in_n, ext_count_in, lpOscIn, sleepIn, intOscActive}),
    .syncOut (pins)
  );

  // Prescale mask as a function of the field
  function automatic logic [2:0] psMask(input logic [1:0] ps);
    logic [2:0] m;
    m = 3'h0;
    unique case (ps)
      2'h0: m = 3'h0;
      2'h1: m = 3'h1;
      2'h2: m = 3'h3;
      2'h3: m = 3'h7;
    endcase
    return m;
  endfunction

  // Read mux, unmapped addresses answer SLVERR
  function automatic logic [33:0] readWord(input gtc_state_t s, input logic [7:0] a);
    logic [33:0] r;
    r = {gtc_pkg::RESP_OKAY, 32'h0000_0000};
    unique case (a)
      gtc_pkg::OFF_COUNT_LOW:  r[7:0] = s.count[7:0];
      gtc_pkg::OFF_COUNT_HIGH: r[7:0] = s.count[15:8];
      gtc_pkg::OFF_STATUS:     r[gtc_pkg::STAT_OVF_BIT] = s.ovfFlag;
      gtc_pkg::OFF_MASK:       r[gtc_pkg::STAT_OVF_BIT] = s.ovfMask;
      gtc_pkg::OFF_CONTROL:    r[7:0] = {1'b0, s.ctl};
      default:                 r[33:32] = gtc_pkg::RESP_SLVERR;
    endcase
    return r;
  endfunction

  logic        instrTick;
  logic        useLpOsc;
  logic        srcLevel;
  logic        srcRise;
  logic        srcFall;
  logic        asyncMode;
  logic        allowed;
  logic        srcTick;
  logic        incTick;
  logic        doWrite;
  logic        wrCount;
  logic [16:0] sum;
  logic [33:0] rd;

  always_comb begin
    st_d = st_q;
    st_d.phase = st_q.phase + 2'h1;
    instrTick  = (st_q.phase == gtc_pkg::PHASE_LAST);

    // oscillator field only honoured on internal oscillator
    useLpOsc = st_q.ctl.oscEn && pins.intOscActive;
    srcLevel = useLpOsc ? pins.lpOsc : pins.extCount;
    st_d.srcPrev = srcLevel;
    srcRise  = srcLevel && !st_q.srcPrev;
    srcFall  = !srcLevel && st_q.srcPrev;
    asyncMode = st_q.ctl.clkSrc && st_q.ctl.noSync;

    allowed = st_q.ctl.runEn && !(st_q.ctl.gateEn && pins.gateN);
    // only the asynchronous counter runs in sleep
    if (pins.sleep && !asyncMode) begin
      allowed = 1'b0;
    end

    // falling edge arms the first rising edge
    if (srcFall) begin
      st_d.armed = 1'b1;
    end
    if (!st_q.ctl.runEn || !st_q.ctl.clkSrc) begin
      st_d.armed = srcFall;
    end

    srcTick = 1'b0;
    if (!st_q.ctl.clkSrc) begin
      // internal source counts Fosc/4, no-sync ignored
      srcTick = instrTick && allowed;
    end else if (st_q.ctl.noSync) begin
      srcTick = srcRise && st_q.armed && allowed;
    end else begin
      // synchronised edge held until cycle boundary
      if (srcRise && st_q.armed && allowed) begin
        st_d.pending = 1'b1;
      end
      if (instrTick) begin
        srcTick      = st_q.pending || (srcRise && st_q.armed && allowed);
        st_d.pending = 1'b0;
      end
    end

    incTick = 1'b0;
    if (srcTick) begin
      st_d.pre = st_q.pre + 3'h1;
      incTick  = ((st_q.pre & psMask(st_q.ctl.prescale)) == psMask(st_q.ctl.prescale));
      if (incTick) begin
        st_d.pre = 3'h0;
      end
    end

    sum = {1'b0, st_q.count} + 17'h00001;
    if (incTick) begin
      st_d.count = sum[15:0];
    end

    // AXI write channels taken independently
    if (s_awvalid && st_q.awRdy) begin
      st_d.awFull = 1'b1;
      st_d.awAddr = s_awaddr;
    end
    if (s_wvalid && st_q.wRdy) begin
      st_d.wFull = 1'b1;
      st_d.wData = s_wdata;
      st_d.wStrb = s_wstrb;
    end
    if (st_q.bValid && s_bready) begin
      st_d.bValid = 1'b0;
    end

    doWrite = st_q.awFull && st_q.wFull && !st_q.bValid;
    wrCount = 1'b0;
    if (doWrite) begin
      st_d.awFull = 1'b0;
      st_d.wFull  = 1'b0;
      st_d.bValid = 1'b1;
      st_d.bResp  = gtc_pkg::RESP_OKAY;
      if (st_q.wStrb[0]) begin
        unique case (st_q.awAddr)
          gtc_pkg::OFF_COUNT_LOW: begin
            st_d.count[7:0] = st_q.wData[7:0];
            wrCount = 1'b1;
          end
          gtc_pkg::OFF_COUNT_HIGH: begin
            st_d.count[15:8] = st_q.wData[7:0];
            wrCount = 1'b1;
          end
          gtc_pkg::OFF_STATUS: begin
            if (st_q.wData[gtc_pkg::STAT_OVF_BIT]) begin
              st_d.ovfFlag = 1'b0;
            end
          end
          gtc_pkg::OFF_MASK:    st_d.ovfMask = st_q.wData[gtc_pkg::STAT_OVF_BIT];
          gtc_pkg::OFF_CONTROL: st_d.ctl = st_q.wData[gtc_pkg::CTL_UNUSED-1:0];
          default:              st_d.bResp = gtc_pkg::RESP_SLVERR;
        endcase
      end else begin
        unique case (st_q.awAddr)
          gtc_pkg::OFF_COUNT_LOW, gtc_pkg::OFF_COUNT_HIGH, gtc_pkg::OFF_STATUS,
          gtc_pkg::OFF_MASK, gtc_pkg::OFF_CONTROL: st_d.bResp = gtc_pkg::RESP_OKAY;
          default: st_d.bResp = gtc_pkg::RESP_SLVERR;
        endcase
      end
    end

    if (wrCount) begin
      st_d.pre     = 3'h0;
      st_d.pending = 1'b0;
    end

    // set wins over a same-cycle clear
    if (incTick && sum[16] && !wrCount) begin
      st_d.ovfFlag = 1'b1;
    end

    // Hold off new writes until the response drains
    st_d.awRdy = !st_d.awFull && !st_d.bValid;
    st_d.wRdy  = !st_d.wFull && !st_d.bValid;

    // read returns the settled count byte
    rd = readWord(st_q, s_araddr);
    if (s_arvalid && st_q.arRdy) begin
      st_d.rValid = 1'b1;
      st_d.rData  = rd[31:0];
      st_d.rResp  = rd[33:32];
    end else if (st_q.rValid && s_rready) begin
      st_d.rValid = 1'b0;
    end
    st_d.arRdy = !st_d.rValid;

    // Outputs registered from next state
    st_d.irqOut  = st_d.ovfFlag && st_d.ovfMask;
    // async overflow wakes a sleeping processor
    st_d.wakeOut = st_d.irqOut && pins.sleep && st_q.ctl.clkSrc && st_q.ctl.noSync;
    st_d.oscOut  = st_d.ctl.oscEn && pins.intOscActive;
  end

  // Single state register
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      st_q         <= '0;
      st_q.ctl     <= gtc_pkg::CONTROL_RESET[gtc_pkg::CTL_UNUSED-1:0];
      st_q.count   <= gtc_pkg::COUNT_RESET;
      st_q.ovfFlag <= gtc_pkg::STATUS_RESET;
      st_q.ovfMask <= gtc_pkg::MASK_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  // Outputs straight from state flops
  assign s_awready   = st_q.awRdy;
  assign s_wready    = st_q.wRdy;
  assign s_bvalid    = st_q.bValid;
  assign s_bresp     = st_q.bResp;
  assign s_arready   = st_q.arRdy;
  assign s_rvalid    = st_q.rValid;
  assign s_rdata     = st_q.rData;
  assign s_rresp     = st_q.rResp;
  assign irq         = st_q.irqOut;
  assign wakeReq     = st_q.wakeOut;
  assign lpOscEnable = st_q.oscOut;

endmodule
`default_nettype wire

//--- dv/gtc_checker.sv
// Purpose: Port-level assertions for the gated timer/counter.
// Assumes: Sees only the top module's ports; one clock domain.
// Notes:   Bound to every timer instance at the foot of this file.
`timescale 1ns/10ps
`default_nettype none
module gtc_checker (
  input wire logic        clock,        // System clock
  input wire logic        rst_n,        // Reset, active low
  input wire logic [7:0]  s_awaddr,     // Write address
  input wire logic        s_awvalid,    // Write address valid
  input wire logic        s_awready,    // Write address ready
  input wire logic        s_wvalid,     // Write data valid
  input wire logic        s_wready,     // Write data ready
  input wire logic [1:0]  s_bresp,      // Write response
  input wire logic        s_bvalid,     // Write response valid
  input wire logic        s_bready,     // Write response ready
  input wire logic [7:0]  s_araddr,     // Read address
  input wire logic        s_arvalid,    // Read address valid
  input wire logic        s_arready,    // Read address ready
  input wire logic [31:0] s_rdata,      // Read data
  input wire logic        s_rvalid,     // Read data valid
  input wire logic        s_rready,     // Read data ready
  input wire logic        intOscActive, // Internal osc active
  input wire logic        lpOscEnable,  // Oscillator enable out
  input wire logic        irq,          // Level interrupt
  input wire logic        wakeReq       // Wake request
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);

  // Handshake steps of one write and one read
  sequence wrTaken;
    s_awvalid && s_awready && s_wvalid && s_wready;
  endsequence
  sequence rdTaken;
    s_arvalid && s_arready;
  endsequence

  a_wr_answer: assert property (wrTaken |-> ##[1:3] s_bvalid)
    else $error("write got no response");
  a_bad_wr_err: assert property (wrTaken ##0 s_awaddr == 8'h14
    |-> ##[1:3] s_bvalid && s_bresp == gtc_pkg::RESP_SLVERR)
    else $error("unmapped write not refused");
  a_rd_answer: assert property (rdTaken |=> s_rvalid)
    else $error("read got no data");
  a_ctl_top_zero: assert property (rdTaken ##0 s_araddr == gtc_pkg::OFF_CONTROL
    |=> s_rvalid && s_rdata[31:7] == 25'h0)
    else $error("control top bits not zero");
  a_b_hold: assert property (s_bvalid && !s_bready |=> s_bvalid && $stable(s_bresp))
    else $error("write response dropped early");
  a_r_hold: assert property (s_rvalid && !s_rready |=> s_rvalid && $stable(s_rdata))
    else $error("read data dropped early");
  a_aw_blocked: assert property (s_bvalid |-> !s_awready && !s_wready)
    else $error("write accepted while response pending");
  a_ar_blocked: assert property (s_rvalid |-> !s_arready)
    else $error("read accepted while data pending");
  a_osc_off: assert property (!intOscActive [*5] |-> !lpOscEnable)
    else $error("oscillator on without internal osc");
  a_wake_irq: assert property (wakeReq |-> irq || $past(irq))
    else $error("wake without interrupt");
endmodule
bind gtc_timer gtc_checker gtc_checker_i (
  .clock        (clock),
  .rst_n        (rst_n),
  .s_awaddr     (s_awaddr),
  .s_awvalid    (s_awvalid),
  .s_awready    (s_awready),
  .s_wvalid     (s_wvalid),
  .s_wready     (s_wready),
  .s_bresp      (s_bresp),
  .s_bvalid     (s_bvalid),
  .s_bready     (s_bready),
  .s_araddr     (s_araddr),
  .s_arvalid    (s_arvalid),
  .s_arready    (s_arready),
  .s_rdata      (s_rdata),
  .s_rvalid     (s_rvalid),
  .s_rready     (s_rready),
  .intOscActive (intOscActive),
  .lpOscEnable  (lpOscEnable),
  .irq          (irq),
  .wakeReq      (wakeReq)
);
`default_nettype wire

//--- dv/gtc_ext_model.sv
// Purpose: Pin-side partner: external count clock and gate signal.
// Assumes: Driven in step with the system clock edges.
// Notes:   Count clock stands low between bursts, like a gated source.
`timescale 1ns/10ps
`default_nettype none
module gtc_ext_model (
  input  wire logic clock,    // System clock
  output logic      extCount, // Count pin level
  output logic      lpOsc,    // Low-power oscillator level
  output logic      gateN     // Gate pin level
);
  // Idle levels: clock low, gate open
  initial begin
    extCount = 1'b0;
    lpOsc    = 1'b0;
    gateN    = 1'b0;
  end

  task automatic pulses(input int n, input int half);
    repeat (n) begin
      @(posedge clock);
      extCount <= 1'b1;
      lpOsc    <= 1'b1;
      repeat (half) @(posedge clock);
      extCount <= 1'b0;
      lpOsc    <= 1'b0;
      repeat (half - 1) @(posedge clock);
    end
  endtask

  task automatic gate(input logic v);
    @(posedge clock);
    gateN <= v;
  endtask
endmodule
`default_nettype wire

//--- dv/gtc_timer_tb.sv
// Purpose: Register-level test of the gated timer/counter.
// Assumes: AXI4-Lite master tasks; pin partner drives count and gate.
// Notes:   Counts are read only with the timer stopped or its gate closed.
`timescale 1ns/10ps
`default_nettype none
module gtc_timer_tb;
  logic        clock, rst_n;
  logic [7:0]  s_awaddr, s_araddr;
  logic [31:0] s_wdata, s_rdata, d;
  logic [3:0]  s_wstrb;
  logic [1:0]  s_bresp, s_rresp, r;
  logic        s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
  logic        s_arvalid, s_arready, s_rvalid, s_rready;
  logic        gate_in_n, ext_count_in, lpOscIn, sleepIn, intOscActive;
  logic        lpOscEnable, irq, wakeReq;
  logic [15:0] c, c2;
  int          err_total, n_checks;

  gtc_timer gtc_timer_i (
    .clock        (clock),
    .rst_n        (rst_n),
    .s_awaddr     (s_awaddr),
    .s_awvalid    (s_awvalid),
    .s_awready    (s_awready),
    .s_wdata      (s_wdata),
    .s_wstrb      (s_wstrb),
    .s_wvalid     (s_wvalid),
    .s_wready     (s_wready),
    .s_bresp      (s_bresp),
    .s_bvalid     (s_bvalid),
    .s_bready     (s_bready),
    .s_araddr     (s_araddr),
    .s_arvalid    (s_arvalid),
    .s_arready    (s_arready),
    .s_rdata      (s_rdata),
    .s_rresp      (s_rresp),
    .s_rvalid     (s_rvalid),
    .s_rready     (s_rready),
    .gate_in_n    (gate_in_n),
    .ext_count_in (ext_count_in),
    .lpOscIn      (lpOscIn),
    .sleepIn      (sleepIn),
    .intOscActive (intOscActive),
    .lpOscEnable  (lpOscEnable),
    .irq          (irq),
    .wakeReq      (wakeReq)
  );
  gtc_ext_model gtc_ext_model_i (.clock(clock), .extCount(ext_count_in),
    .lpOsc(lpOscIn), .gateN(gate_in_n));

  // 50 MHz clock
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // Both write channels offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic aw, w;
    aw = 1'b1;
    w  = 1'b1;
    @(posedge clock);
    s_awaddr  <= a;
    s_wdata   <= v;
    s_awvalid <= 1'b1;
    s_wvalid  <= 1'b1;
    while (aw || w) begin
      @(posedge clock);
      if (s_awready) begin
        aw = 1'b0;
        s_awvalid <= 1'b0;
      end
      if (s_wready) begin
        w = 1'b0;
        s_wvalid <= 1'b0;
      end
    end
    while (!s_bvalid) @(posedge clock);
    // Late ready lets the response be held a cycle
    s_bready <= 1'b1;
    @(posedge clock);
    r = s_bresp;
    s_bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clock);
    s_araddr  <= a;
    s_arvalid <= 1'b1;
    do @(posedge clock); while (!s_arready);
    s_arvalid <= 1'b0;
    do @(posedge clock); while (!s_rvalid);
    // Late ready lets the read data be held a cycle
    s_rready <= 1'b1;
    @(posedge clock);
    v = s_rdata;
    r = s_rresp;
    s_rready <= 1'b0;
  endtask

  // two byte reads; stop the timer first
  task automatic rcnt(output logic [15:0] v);
    logic [31:0] lo, hi;
    rd(gtc_pkg::OFF_COUNT_LOW, lo);
    rd(gtc_pkg::OFF_COUNT_HIGH, hi);
    v = {hi[7:0], lo[7:0]};
  endtask

  task automatic setcnt(input logic [15:0] v);
    wr(gtc_pkg::OFF_COUNT_LOW, {24'h0, v[7:0]});
    wr(gtc_pkg::OFF_COUNT_HIGH, {24'h0, v[15:8]});
  endtask

  task automatic tally_and_finish;
    $display("Checks %0d, errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    {s_awaddr, s_araddr, s_wdata, s_awvalid, s_wvalid, s_bready} = '0;
    {s_arvalid, s_rready, sleepIn, intOscActive} = '0;
    s_wstrb = 4'hf;
    rst_n = 1'b0;
    repeat (8) @(posedge clock);
    rst_n <= 1'b1;
    repeat (2) @(posedge clock);
    rd(gtc_pkg::OFF_CONTROL, d);
    chk(d, 32'h0);
    chk(32'(r), 32'(gtc_pkg::RESP_OKAY));
    wr(gtc_pkg::OFF_CONTROL, 32'hff);
    rd(gtc_pkg::OFF_CONTROL, d);
    chk(d, 32'h7f);
    s_wstrb <= 4'he;
    wr(gtc_pkg::OFF_CONTROL, 32'h0);
    s_wstrb <= 4'hf;
    chk(32'(r), 32'(gtc_pkg::RESP_OKAY));
    rd(gtc_pkg::OFF_CONTROL, d);
    chk(d, 32'h7f);
    wr(8'h14, 32'h1);
    chk(32'(r), 32'(gtc_pkg::RESP_SLVERR));
    rd(8'h14, d);
    chk(32'(r), 32'(gtc_pkg::RESP_SLVERR));
    chk(d, 32'h0);
    for (int p = 0; p < 4; p++) begin
      wr(gtc_pkg::OFF_CONTROL, 32'h0);
      setcnt(16'h0);
      wr(gtc_pkg::OFF_CONTROL, 32'h1 | (p << 4));
      repeat (256 << p) @(posedge clock);
      wr(gtc_pkg::OFF_CONTROL, 32'h0);
      rcnt(c);
      chk(32'(c >= 62 && c <= 66), 32'h1);
      repeat (40) @(posedge clock);
      rcnt(c2);
      chk(32'(c2), 32'(c));
    end
    setcnt(16'h0);
    sleepIn <= 1'b1;
    wr(gtc_pkg::OFF_CONTROL, 32'h5);
    repeat (100) @(posedge clock);
    wr(gtc_pkg::OFF_CONTROL, 32'h0);
    sleepIn <= 1'b0;
    rcnt(c);
    chk(32'(c), 32'h0);
    gtc_ext_model_i.gate(1'b1);
    wr(gtc_pkg::OFF_CONTROL, 32'h41);
    repeat (100) @(posedge clock);
    rcnt(c);
    chk(32'(c), 32'h0);
    gtc_ext_model_i.gate(1'b0);
    repeat (100) @(posedge clock);
    wr(gtc_pkg::OFF_CONTROL, 32'h0);
    rcnt(c);
    chk(32'(c >= 22 && c <= 29), 32'h1);
    for (int ns = 0; ns < 2; ns++) begin
      setcnt(16'h0);
      wr(gtc_pkg::OFF_CONTROL, 32'h3 | (ns << 2));
      gtc_ext_model_i.pulses(10, 8);
      repeat (10) @(posedge clock);
      wr(gtc_pkg::OFF_CONTROL, 32'h0);
      rcnt(c);
      chk(32'(c), 32'd9);
    end
    // Nine edges at 1:2 leave the prescaler half full
    setcnt(16'h0);
    wr(gtc_pkg::OFF_CONTROL, 32'h17);
    gtc_ext_model_i.pulses(10, 8);
    repeat (10) @(posedge clock);
    wr(gtc_pkg::OFF_CONTROL, 32'h0);
    rcnt(c);
    chk(32'(c), 32'd4);
    setcnt(16'h0);
    wr(gtc_pkg::OFF_CONTROL, 32'h17);
    gtc_ext_model_i.pulses(2, 8);
    repeat (10) @(posedge clock);
    wr(gtc_pkg::OFF_CONTROL, 32'h0);
    rcnt(c);
    chk(32'(c), 32'h0);
    wr(gtc_pkg::OFF_MASK, 32'h1);
    setcnt(16'hfffe);
    sleepIn <= 1'b1;
    wr(gtc_pkg::OFF_CONTROL, 32'h7);
    gtc_ext_model_i.pulses(3, 8);
    repeat (10) @(posedge clock);
    chk(32'(wakeReq), 32'h1);
    chk(32'(irq), 32'h1);
    sleepIn <= 1'b0;
    wr(gtc_pkg::OFF_CONTROL, 32'h0);
    rcnt(c);
    chk(32'(c), 32'h0);
    rd(gtc_pkg::OFF_STATUS, d);
    chk(d, 32'h1);
    wr(gtc_pkg::OFF_MASK, 32'h0);
    repeat (2) @(posedge clock);
    chk(32'(irq), 32'h0);
    wr(gtc_pkg::OFF_MASK, 32'h1);
    repeat (2) @(posedge clock);
    chk(32'(irq), 32'h1);
    wr(gtc_pkg::OFF_STATUS, 32'h1);
    repeat (2) @(posedge clock);
    chk(32'(irq), 32'h0);
    intOscActive <= 1'b1;
    wr(gtc_pkg::OFF_CONTROL, 32'h8);
    repeat (6) @(posedge clock);
    chk(32'(lpOscEnable), 32'h1);
    intOscActive <= 1'b0;
    repeat (6) @(posedge clock);
    chk(32'(lpOscEnable), 32'h0);
    tally_and_finish();
  end

  // Hang guard, well beyond the expected run length
  initial begin
    repeat (30000) @(posedge clock);
    err_total++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
